// file: fspc_pkg.sv
package fspc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ      = 200;
  localparam int unsigned PULSE_NS     = 250;
  // typical width, rounded up to whole cycles
  localparam int unsigned PULSE_CYCLES = (PULSE_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  OFF_CFG     = 8'h00;
  localparam logic [7:0]  OFF_STATUS  = 8'h04;
  localparam logic [7:0]  OFF_IRQ_STS = 8'h08;
  localparam logic [7:0]  OFF_IRQ_MSK = 8'h0C;

  // ----------------------------------------------------------------
  // command data layout
  // ----------------------------------------------------------------
  localparam int unsigned CMD_W    = 8;
  localparam int unsigned CODE_W   = 2;
  localparam int unsigned RSVD_LSB = 2;
  localparam int unsigned RSVD_W   = 6;

  // ----------------------------------------------------------------
  // status and interrupt bits
  // ----------------------------------------------------------------
  localparam int unsigned ST_SEQ    = 8;
  localparam int unsigned ST_RDY    = 7;
  localparam int unsigned ST_EE     = 5;
  localparam int unsigned ST_PE     = 4;
  localparam int unsigned IRQ_ERASE = 0;
  localparam int unsigned IRQ_PROG  = 1;
  localparam int unsigned IRQ_CFG   = 2;
  localparam int unsigned IRQ_W     = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_LEVEL       = 2'b00,
    MODE_PULSE_ERASE = 2'b01,
    MODE_PULSE_PROG  = 2'b10,
    MODE_PULSE_ANY   = 2'b11
  } fspc_mode_t;

  typedef enum logic [2:0] {
    SEL_NONE    = 3'b000,
    SEL_CFG     = 3'b001,
    SEL_STATUS  = 3'b010,
    SEL_IRQ_STS = 3'b011,
    SEL_IRQ_MSK = 3'b100
  } fspc_sel_t;

endpackage : fspc_pkg

// file: fspc_pulse_gen.sv
module fspc_pulse_gen #(
  parameter int unsigned CYCLES = fspc_pkg::PULSE_CYCLES
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  input  wire logic i_trigger,
  output logic      o_active
);

  localparam int unsigned CNT_W = $clog2(CYCLES + 1);

  logic [CNT_W-1:0] cnt_q;
  logic             active_q;

  // one-shot; a trigger during a pulse merges into it
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      active_q <= 1'b0;
      cnt_q    <= '0;
    end else if (!active_q) begin
      if (i_trigger) begin
        active_q <= 1'b1;
        cnt_q    <= CNT_W'(CYCLES - 1);
      end
    end else if (cnt_q == '0) begin
      active_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q - CNT_W'(1);
    end
  end

  assign o_active = active_q;

endmodule : fspc_pulse_gen

// file: fspc_axil_slave.sv
module fspc_axil_slave #(
  parameter int unsigned ADDR_W = fspc_pkg::ADDR_W
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [ADDR_W-1:0] i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  output logic                   o_wr_en,
  output logic [ADDR_W-1:0]      o_wr_addr,
  output logic [31:0]            o_wr_data,
  output logic [3:0]             o_wr_strb,
  input  wire logic              i_wr_err,
  output logic                   o_rd_en,
  output logic [ADDR_W-1:0]      o_rd_addr,
  input  wire logic [31:0]       i_rd_data,
  input  wire logic              i_rd_err
);

  logic              awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q, rdata_q;
  logic [3:0]        wstrb_q;
  logic [1:0]        bresp_q, rresp_q;

  // address and data are captured in either order
  assign o_wr_en   = !awready_q && !wready_q && !bvalid_q;
  assign o_wr_addr = awaddr_q;
  assign o_wr_data = wdata_q;
  assign o_wr_strb = wstrb_q;
  assign o_rd_en   = i_arvalid && arready_q;
  assign o_rd_addr = i_araddr;

  // write channels
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= fspc_pkg::RESP_OKAY;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end else begin
      if (i_awvalid && awready_q) begin
        awready_q <= 1'b0;
        awaddr_q  <= i_awaddr;
      end
      if (i_wvalid && wready_q) begin
        wready_q <= 1'b0;
        wdata_q  <= i_wdata;
        wstrb_q  <= i_wstrb;
      end
      if (o_wr_en) begin
        bvalid_q <= 1'b1;
        bresp_q  <= i_wr_err ? fspc_pkg::RESP_SLVERR : fspc_pkg::RESP_OKAY;
      end else if (bvalid_q && i_bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // read channels, answer one cycle after the address
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= fspc_pkg::RESP_OKAY;
    end else if (o_rd_en) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= i_rd_data;
      rresp_q   <= i_rd_err ? fspc_pkg::RESP_SLVERR : fspc_pkg::RESP_OKAY;
    end else if (rvalid_q && i_rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign o_awready = awready_q;
  assign o_wready  = wready_q;
  assign o_bvalid  = bvalid_q;
  assign o_bresp   = bresp_q;
  assign o_arready = arready_q;
  assign o_rvalid  = rvalid_q;
  assign o_rdata   = rdata_q;
  assign o_rresp   = rresp_q;

endmodule : fspc_axil_slave

// file: fspc_top.sv
// Contract
// RULE_01 - status pin runs in level or pulse mode, chosen by config command
// RULE_02 - selected mode holds until reset or another config command
// RULE_03 - reset puts the pin into level mode, code 00
// RULE_04 - level mode shows write state machine busy, like ready/busy
// RULE_05 - host issues config only when not busy and not suspended
// RULE_06 - code sits in the two low data bits; upper six reserved
// RULE_07 - code 01 pulses the pin on every block erase completion
// RULE_08 - code 10 pulses the pin on every program completion
// RULE_09 - code 11 pulses the pin on erase or program completion
// RULE_10 - each pulse drives the pin low for 250 ns, then high
// RULE_11 - invalid code sets both program and erase error bits
// RULE_12 - both error bits set read as a command sequence error; the code shows it only while not busy
// RULE_13 - reset clears the status register including error bits
// RULE_14 - level mode: pin low while busy, high once ready
module fspc_top #(
  parameter int unsigned ADDR_W       = fspc_pkg::ADDR_W,
  parameter int unsigned PULSE_CYCLES = fspc_pkg::PULSE_CYCLES
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_wsm_busy,
  input  wire logic              i_erase_done,
  input  wire logic              i_program_done,
  input  wire logic              i_erase_fail,
  input  wire logic              i_program_fail,
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [ADDR_W-1:0] i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  output logic                   o_status_pin,
  output logic                   o_irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int PW_I = PULSE_CYCLES;

  fspc_pkg::fspc_mode_t          mode_q;
  logic                          pin_q;
  logic                          irq_q;
  logic                          erase_err_q;
  logic                          prog_err_q;
  logic [fspc_pkg::IRQ_W-1:0]    irq_sts_q;
  logic [fspc_pkg::IRQ_W-1:0]    irq_msk_q;
  logic [fspc_pkg::IRQ_W-1:0]    irq_evt;
  logic [fspc_pkg::IRQ_W-1:0]    irq_clr;
  logic                          wr_en;
  logic [ADDR_W-1:0]             wr_addr;
  logic [31:0]                   wr_data;
  logic [3:0]                    wr_strb;
  logic                          wr_err;
  logic                          rd_en;
  logic [ADDR_W-1:0]             rd_addr;
  logic [31:0]                   rd_data;
  logic                          rd_err;
  logic [31:0]                   status_word;
  logic [fspc_pkg::CMD_W-1:0]    cmd;
  logic                          cfg_cmd;
  logic                          cfg_invalid;
  logic                          cfg_valid;
  logic                          st_clr_wr;
  logic                          pulse_trig;
  logic                          pulse_active;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // low two address bits are ignored: every register is one word
  function automatic fspc_pkg::fspc_sel_t reg_sel(
    input logic [ADDR_W-1:0] addr
  );
    logic [ADDR_W-1:0] a;
    a = {addr[ADDR_W-1:2], 2'h0};
    if (a == ADDR_W'(fspc_pkg::OFF_CFG)) begin
      return fspc_pkg::SEL_CFG;
    end else if (a == ADDR_W'(fspc_pkg::OFF_STATUS)) begin
      return fspc_pkg::SEL_STATUS;
    end else if (a == ADDR_W'(fspc_pkg::OFF_IRQ_STS)) begin
      return fspc_pkg::SEL_IRQ_STS;
    end else if (a == ADDR_W'(fspc_pkg::OFF_IRQ_MSK)) begin
      return fspc_pkg::SEL_IRQ_MSK;
    end else begin
      return fspc_pkg::SEL_NONE;
    end
  endfunction : reg_sel

  // pulse source for each mode
  function automatic logic mode_trigger(
    input fspc_pkg::fspc_mode_t m,
    input logic                 erase_done,
    input logic                 prog_done
  );
    logic t;
    t = 1'b0;
    case (m)
      fspc_pkg::MODE_PULSE_ERASE: t = erase_done;
      fspc_pkg::MODE_PULSE_PROG:  t = prog_done;
      fspc_pkg::MODE_PULSE_ANY:   t = erase_done || prog_done;
      default:                    t = 1'b0;
    endcase
    return t;
  endfunction : mode_trigger

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  fspc_axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_axil (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_awaddr  (i_awaddr),
    .i_awvalid (i_awvalid),
    .o_awready (o_awready),
    .i_wdata   (i_wdata),
    .i_wstrb   (i_wstrb),
    .i_wvalid  (i_wvalid),
    .o_wready  (o_wready),
    .o_bresp   (o_bresp),
    .o_bvalid  (o_bvalid),
    .i_bready  (i_bready),
    .i_araddr  (i_araddr),
    .i_arvalid (i_arvalid),
    .o_arready (o_arready),
    .o_rdata   (o_rdata),
    .o_rresp   (o_rresp),
    .o_rvalid  (o_rvalid),
    .i_rready  (i_rready),
    .o_wr_en   (wr_en),
    .o_wr_addr (wr_addr),
    .o_wr_data (wr_data),
    .o_wr_strb (wr_strb),
    .i_wr_err  (wr_err),
    .o_rd_en   (rd_en),
    .o_rd_addr (rd_addr),
    .i_rd_data (rd_data),
    .i_rd_err  (rd_err)
  );

  // ----------------------------------------------------------------
  // configuration command
  // ----------------------------------------------------------------
  // RULE_06 code field
  assign cmd         = wr_data[fspc_pkg::CMD_W-1:0];
  assign cfg_cmd     = wr_en && wr_strb[0] &&
                       (reg_sel(wr_addr) == fspc_pkg::SEL_CFG);
  assign cfg_invalid = cfg_cmd &&
                       (cmd[fspc_pkg::RSVD_LSB +: fspc_pkg::RSVD_W] != '0);
  assign cfg_valid   = cfg_cmd && !cfg_invalid;
  assign wr_err      = (reg_sel(wr_addr) == fspc_pkg::SEL_NONE);
  assign st_clr_wr   = wr_en && wr_strb[0] &&
                       (reg_sel(wr_addr) == fspc_pkg::SEL_STATUS);

  // RULE_01 mode select
  // RULE_02 mode holds
  // RULE_03 reset to level
  // accepted in any state: the host only issues it while idle (RULE_05)
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      mode_q <= fspc_pkg::MODE_LEVEL;
    end else if (cfg_valid) begin
      mode_q <= fspc_pkg::fspc_mode_t'(cmd[fspc_pkg::CODE_W-1:0]);
    end
  end

  // ----------------------------------------------------------------
  // error bits
  // ----------------------------------------------------------------
  // RULE_11 invalid sets both
  // RULE_13 reset clears
  // a fresh error wins over a clear in the same cycle
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      erase_err_q <= 1'b0;
      prog_err_q  <= 1'b0;
    end else begin
      if (cfg_invalid || i_erase_fail) begin
        erase_err_q <= 1'b1;
      end else if (st_clr_wr && wr_data[fspc_pkg::ST_EE]) begin
        erase_err_q <= 1'b0;
      end
      if (cfg_invalid || i_program_fail) begin
        prog_err_q <= 1'b1;
      end else if (st_clr_wr && wr_data[fspc_pkg::ST_PE]) begin
        prog_err_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // completion pulse
  // ----------------------------------------------------------------
  // RULE_07 erase trigger
  // RULE_08 program trigger
  // RULE_09 either trigger
  assign pulse_trig = mode_trigger(mode_q, i_erase_done, i_program_done);

  // RULE_10 pulse width
  fspc_pulse_gen #(
    .CYCLES (PULSE_CYCLES)
  ) u_pulse (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_trigger (pulse_trig),
    .o_active  (pulse_active)
  );

  // RULE_04 busy indication
  // RULE_14 low while busy
  // pin idles high in pulse modes, so pulses are active low
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      pin_q <= 1'b1;
    end else if (mode_q == fspc_pkg::MODE_LEVEL) begin
      pin_q <= !i_wsm_busy;
    end else begin
      pin_q <= !pulse_active;
    end
  end

  assign o_status_pin = pin_q;

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  assign irq_evt[fspc_pkg::IRQ_ERASE] = i_erase_done;
  assign irq_evt[fspc_pkg::IRQ_PROG]  = i_program_done;
  assign irq_evt[fspc_pkg::IRQ_CFG]   = cfg_invalid;
  assign irq_clr = (wr_en && wr_strb[0] &&
                    (reg_sel(wr_addr) == fspc_pkg::SEL_IRQ_STS)) ?
                   wr_data[fspc_pkg::IRQ_W-1:0] : '0;

  // sticky status, set beats write-one-to-clear
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      irq_sts_q <= '0;
    end else begin
      irq_sts_q <= irq_evt | (irq_sts_q & ~irq_clr);
    end
  end

  // mask, all events masked after reset
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      irq_msk_q <= '0;
    end else if (wr_en && wr_strb[0] &&
                 (reg_sel(wr_addr) == fspc_pkg::SEL_IRQ_MSK)) begin
      irq_msk_q <= wr_data[fspc_pkg::IRQ_W-1:0];
    end
  end

  // registered level, one cycle behind the status bits
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_sts_q & irq_msk_q);
    end
  end

  assign o_irq = irq_q;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // RULE_12 sequence error view
  always_comb begin
    status_word                   = '0;
    status_word[fspc_pkg::ST_RDY] = !i_wsm_busy;
    status_word[fspc_pkg::ST_EE]  = erase_err_q;
    status_word[fspc_pkg::ST_PE]  = prog_err_q;
    status_word[fspc_pkg::ST_SEQ] = !i_wsm_busy && erase_err_q && prog_err_q;
  end

  always_comb begin
    rd_data = '0;
    rd_err  = 1'b0;
    case (reg_sel(rd_addr))
      fspc_pkg::SEL_CFG:     rd_data = 32'(mode_q);
      fspc_pkg::SEL_STATUS:  rd_data = status_word;
      fspc_pkg::SEL_IRQ_STS: rd_data = 32'(irq_sts_q);
      fspc_pkg::SEL_IRQ_MSK: rd_data = 32'(irq_msk_q);
      default:               rd_err  = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  a_mode_take_code: assert property ( // RULE_01
    cfg_valid |=> mode_q == $past(cmd[1:0]))
    else $error("mode did not take the command code");

  a_mode_hold_idle: assert property ( // RULE_02
    !cfg_valid |=> $stable(mode_q))
    else $error("mode changed without a command");

  // reset is the trigger here, so the default disable must not apply
  a_reset_level_mode: assert property ( // RULE_03
    @(posedge i_sys_clk) disable iff (1'b0)
    !i_rst_n |=> mode_q == fspc_pkg::MODE_LEVEL && pin_q)
    else $error("reset did not restore level mode");

  a_level_pin_busy: assert property ( // RULE_14
    mode_q == fspc_pkg::MODE_LEVEL |=> o_status_pin == !$past(i_wsm_busy))
    else $error("level mode pin does not follow busy");

  a_reserved_rejects: assert property ( // RULE_06
    cfg_invalid |=> $stable(mode_q) && irq_sts_q[fspc_pkg::IRQ_CFG])
    else $error("reserved bits did not reject the command");

  a_invalid_errors: assert property ( // RULE_11
    cfg_invalid |=> prog_err_q && erase_err_q)
    else $error("invalid code did not set both error bits");

  a_erase_pulse_go: assert property ( // RULE_07
    mode_q == fspc_pkg::MODE_PULSE_ERASE && i_erase_done && !pulse_active
    |=> pulse_active ##1 !o_status_pin)
    else $error("erase completion gave no pulse");

  a_prog_pulse_go: assert property ( // RULE_08
    mode_q == fspc_pkg::MODE_PULSE_PROG && !pulse_active
    |=> pulse_active == $past(i_program_done))
    else $error("program pulse does not match completion");

  a_any_pulse_go: assert property ( // RULE_09
    mode_q == fspc_pkg::MODE_PULSE_ANY && !pulse_active
    |=> pulse_active == $past(i_erase_done || i_program_done))
    else $error("combined mode pulse mismatch");

  a_pulse_width: assert property ( // RULE_10
    $rose(pulse_active) |-> ##[PW_I:PW_I] $fell(pulse_active))
    else $error("pulse width is wrong");

  a_pulse_pin_low: assert property ( // RULE_10
    mode_q != fspc_pkg::MODE_LEVEL |=> o_status_pin == !$past(pulse_active))
    else $error("pulse mode pin does not follow the pulse");

  a_seq_err_view: assert property ( // RULE_12
    cfg_invalid |=> status_word[fspc_pkg::ST_SEQ] == !i_wsm_busy)
    else $error("invalid code did not show a sequence error");

  a_reset_clears_sr: assert property ( // RULE_13
    @(posedge i_sys_clk) disable iff (1'b0)
    !i_rst_n |=> !prog_err_q && !erase_err_q)
    else $error("reset did not clear the error bits");

  c_erase_pulse: cover property (
    mode_q == fspc_pkg::MODE_PULSE_ERASE && $rose(pulse_active));
  c_invalid_cmd: cover property (cfg_invalid);
  c_back_to_level: cover property (
    mode_q != fspc_pkg::MODE_LEVEL ##1 mode_q == fspc_pkg::MODE_LEVEL);

endmodule : fspc_top

// file: fspc_wsm_model.sv
module fspc_wsm_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_go,
  input  wire logic       i_erase,
  input  wire logic [7:0] i_len,
  output logic            o_busy,
  output logic            o_erase_done,
  output logic            o_program_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;
  logic       ers_q;
  initial begin
    o_busy         = 1'b0;
    o_erase_done   = 1'b0;
    o_program_done = 1'b0;
    cnt_q          = 8'h00;
    ers_q          = 1'b0;
  end
  // busy for i_len cycles, then one done pulse of the operation's kind
  always @(posedge i_sys_clk) begin
    o_erase_done   <= 1'b0;
    o_program_done <= 1'b0;
    if (i_go) begin
      o_busy <= 1'b1;
      cnt_q  <= i_len;
      ers_q  <= i_erase;
    end else if (o_busy && cnt_q == 8'h01) begin
      o_busy         <= 1'b0;
      o_erase_done   <= ers_q;
      o_program_done <= !ers_q;
    end else if (o_busy) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule : fspc_wsm_model

// file: test_flash_status_pin_config.sv
module test_flash_status_pin_config;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PW = 8;
  logic i_sys_clk = 0, i_rst_n = 0, go = 0, ers = 0;
  logic [7:0] len = 8'h01, awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 32'h0, rd;
  logic [1:0]  rsp;
  logic busy, edone, pdone, awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic pin, irq;
  int mismatches = 0, num_checks = 0, seed = 32'h580abafe, l;
  always #2.5 i_sys_clk = ~i_sys_clk;
  fspc_wsm_model wsm (.i_sys_clk(i_sys_clk), .i_go(go), .i_erase(ers),
    .i_len(len), .o_busy(busy), .o_erase_done(edone),
    .o_program_done(pdone));
  fspc_top #(.PULSE_CYCLES(PW)) uut (.i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n), .i_wsm_busy(busy), .i_erase_done(edone),
    .i_program_done(pdone), .i_erase_fail(1'b0), .i_program_fail(1'b0),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .o_status_pin(pin), .o_irq(irq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    if (mismatches == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  // address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    awaddr <= a; awvalid <= 1; wdata <= d; wvalid <= 1; bready <= 1;
    // bready stays up, so the answer may come in any pass of the loop
    do begin
      @(posedge i_sys_clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge i_sys_clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge i_sys_clk);
      if (arvalid && arready) arvalid <= 0;
    end while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 0;
  endtask : axr
  function automatic int exp_low(input logic [1:0] m, input logic e,
                                 input int n);
    if (m == 2'b00) return n;
    if ((m == 2'b01 && e) || (m == 2'b10 && !e) || m == 2'b11) return PW;
    return 0;
  endfunction : exp_low
  // one operation, counting the cycles the pin spends low
  task automatic run_op(input logic e, input int n, input logic [1:0] m);
    int low;
    low = 0;
    @(posedge i_sys_clk);
    go <= 1; ers <= e; len <= n[7:0];
    @(posedge i_sys_clk);
    go <= 0;
    repeat (n + PW + 8) begin
      @(negedge i_sys_clk);
      if (pin !== 1'b1) low++;
    end
    chk(32'(low), 32'(exp_low(m, e, n)));
  endtask : run_op
  task automatic do_reset();
    @(posedge i_sys_clk);
    i_rst_n <= 0;
    repeat (6) @(posedge i_sys_clk);
    i_rst_n <= 1;
    @(negedge i_sys_clk);
    chk({31'h0, pin}, 32'h1);
    axr(fspc_pkg::OFF_CFG);
    chk(rd, 32'h0);
    axr(fspc_pkg::OFF_STATUS);
    chk(rd, 32'h80);
  endtask : do_reset
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    mismatches++;
    report_and_stop();
  end
  initial begin
    do_reset();
    // every code in turn, both operation kinds twice, the first one cycle long, the rest 1 to 20 cycles at random
    for (int m = 0; m < 4; m++) begin
      axw(fspc_pkg::OFF_CFG, 32'(m));
      chk({30'h0, rsp}, {30'h0, fspc_pkg::RESP_OKAY});
      axr(fspc_pkg::OFF_CFG);
      chk(rd, 32'(m));
      chk({30'h0, rsp}, {30'h0, fspc_pkg::RESP_OKAY});
      for (int k = 0; k < 4; k++) begin
        l = (k == 0) ? 1 : 1 + ({$random(seed)} % 20);
        run_op(k[0], l, m[1:0]);
      end
    end
    axw(fspc_pkg::OFF_IRQ_STS, 32'h7);
    axw(fspc_pkg::OFF_CFG, 32'(({$random(seed)} % 63 + 1) << 2) | 32'h3);
    axr(fspc_pkg::OFF_CFG);
    chk(rd, 32'h3);
    axr(fspc_pkg::OFF_STATUS);
    chk(rd, 32'h1B0);
    axr(fspc_pkg::OFF_IRQ_STS);
    chk(rd, 32'h4);
    chk({31'h0, irq}, 32'h0);
    axw(fspc_pkg::OFF_IRQ_MSK, 32'h4);
    repeat (3) @(negedge i_sys_clk);
    chk({31'h0, irq}, 32'h1);
    axw(fspc_pkg::OFF_IRQ_STS, 32'h4);
    repeat (3) @(negedge i_sys_clk);
    chk({31'h0, irq}, 32'h0);
    axw(8'h10, 32'h0);
    chk({30'h0, rsp}, {30'h0, fspc_pkg::RESP_SLVERR});
    axr(8'h10);
    chk({30'h0, rsp}, {30'h0, fspc_pkg::RESP_SLVERR});
    do_reset();
    run_op(1'b1, 5, 2'b00);
    report_and_stop();
  end
endmodule : test_flash_status_pin_config
